// ===== hdl/ccc_core.sv
// Purpose: Charge cycle controller with routing switch control and AHB-Lite registers
// Assumes: Comparator inputs are asynchronous pins; one 50 MHz clock
// Notes: Events are sticky in the event register, cleared by writing one
//
// The register addresses and the AHB-Lite register port were decided locally.
`timescale 1ns/100ps
`include "ccc_cfg.svh"
module ccc_core import ccc_pkg::*; #(
	parameter logic [63:0] PRE_CYC = `CCC_PRE_CYC,
	parameter logic [63:0] FULL_CYC = `CCC_FULL_CYC,
	parameter logic [31:0] IN_RISE_CYC = `CCC_IN_RISE_CYC,
	parameter logic [31:0] DG_LONG_CYC = `CCC_DG_LONG_CYC,
	parameter logic [31:0] DG_SHORT_CYC = `CCC_DG_SHORT_CYC
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [11:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Analog comparators
	input wire ccc_comp_t comp_in,
	// Power stage controls
	output ccc_drive_t drive_out
);
	localparam logic [31:0] IN_FALL_CYC = `CCC_IN_FALL_CYC;

	// Synchronised and filtered comparator levels
	ccc_comp_t sync1_reg;
	ccc_comp_t sync2_reg;
	logic in_ok;
	logic full_ok;
	logic restart_ok;
	logic eoc_cur_ok;
	logic [31:0] dg_cyc;

	// Registers and state
	logic [31:0] ctrl_reg;
	logic [3:0] event_reg;
	ccc_state_t state_reg;
	logic switch_reg;
	logic in_ok_q_reg;
	logic cycle_done_reg;
	logic [63:0] timer_reg;
	logic [31:0] eoc_cnt_reg;
	logic [31:0] rst_cnt_reg;

	// Bus pipeline
	logic wr_pend_reg;
	logic rd_pend_reg;
	logic [11:0] addr_reg;

	// Decoded commands and conditions
	logic wr_cmd;
	logic wr_ctrl;
	logic wr_event;
	logic cmd_begin;
	logic cmd_halt;
	logic cmd_close;
	logic cmd_open;
	logic auto_en;
	logic heavy;
	logic eoc_below;
	logic eoc_hit;
	logic restart_hit;
	logic overload_close;
	logic timer_exp;

	// Two-flop synchroniser for every comparator pin
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			sync1_reg <= '0;
			sync2_reg <= '0;
		end else begin
			sync1_reg <= comp_in;
			sync2_reg <= sync1_reg;
		end
	end

	// Selectable comparator deglitch
	assign dg_cyc = ctrl_reg[`CCC_CTRL_LONG_DG_BIT] ? DG_LONG_CYC : DG_SHORT_CYC;

	// Input range filter, asymmetric
	ccc_deglitch u_in_dg (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.level_in(sync2_reg.in_range),
		.rise_cyc(IN_RISE_CYC),
		.fall_cyc(IN_FALL_CYC),
		.level_out(in_ok)
	);

	// Full-rate level filter
	ccc_deglitch u_full_dg (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.level_in(sync2_reg.above_full_rate),
		.rise_cyc(dg_cyc),
		.fall_cyc(dg_cyc),
		.level_out(full_ok)
	);

	// Restart level filter
	ccc_deglitch u_rst_dg (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.level_in(sync2_reg.below_restart),
		.rise_cyc(dg_cyc),
		.fall_cyc(dg_cyc),
		.level_out(restart_ok)
	);

	// End-of-charge current threshold chosen by absolute-select
	assign eoc_below = ctrl_reg[`CCC_CTRL_EOC_ABS_BIT] ? sync2_reg.cur_below_abs :
		sync2_reg.cur_below_rel;

	// End-of-charge current filter
	ccc_deglitch u_eoc_dg (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.level_in(eoc_below),
		.rise_cyc(dg_cyc),
		.fall_cyc(32'h0000_0001),
		.level_out(eoc_cur_ok)
	);

	// Bus address phase capture
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			wr_pend_reg <= 1'b0;
			rd_pend_reg <= 1'b0;
			addr_reg <= 12'h000;
		end else if (hready) begin
			wr_pend_reg <= hsel & htrans[1] & hwrite & (hsize == 3'h2);
			rd_pend_reg <= hsel & htrans[1] & ~hwrite;
			addr_reg <= haddr;
		end
	end

	// Write decode in the data phase
	assign wr_ctrl = wr_pend_reg & (addr_reg == `CCC_CTRL_OFS);
	assign wr_cmd = wr_pend_reg & (addr_reg == `CCC_CMD_OFS);
	assign wr_event = wr_pend_reg & (addr_reg == `CCC_EVENT_OFS);
	// Write-only command strobes, never stored; auto and heavy bits from the control register
	assign cmd_begin = wr_cmd & hwdata[`CCC_CMD_BEGIN_BIT];
	assign cmd_halt = wr_cmd & hwdata[`CCC_CMD_HALT_BIT];
	assign cmd_close = wr_cmd & hwdata[`CCC_CMD_CLOSE_BIT];
	assign cmd_open = wr_cmd & hwdata[`CCC_CMD_OPEN_BIT];
	assign auto_en = ctrl_reg[`CCC_CTRL_AUTO_BIT];
	assign heavy = ctrl_reg[`CCC_CTRL_HEAVY_BIT];

	// Bus always ready and OKAY
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	// Read data, registered from address phase
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			hrdata <= 32'h0000_0000;
		end else if (hready && hsel && htrans[1] && !hwrite) begin
			unique case (haddr)
				`CCC_CTRL_OFS: hrdata <= ctrl_reg;
				`CCC_STATUS_OFS: hrdata <= {24'h00_0000, cycle_done_reg, in_ok,
					switch_reg, 2'h0, state_reg};
				`CCC_EVENT_OFS: hrdata <= {28'h000_0000, event_reg};
				default: hrdata <= 32'h0000_0000;
			endcase
		end
	end

	// Control register
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			ctrl_reg <= `CCC_CTRL_RESET;
		end else if (wr_ctrl) begin
			ctrl_reg <= {16'h0000, hwdata[15:8], 3'h0, hwdata[4:0]};
		end
	end

	// End-of-charge qualified only at termination voltage in constant voltage
	assign eoc_hit = (state_reg == CCC_CONST_VOLT) & sync2_reg.at_term & eoc_cur_ok;
	// Restart armed only in standby after a completed cycle
	assign restart_hit = (state_reg == CCC_STANDBY) & cycle_done_reg & restart_ok &
		ctrl_reg[`CCC_CTRL_RESTART_EN_BIT];
	assign overload_close = in_ok & ~switch_reg & sync2_reg.overload & ~heavy;
	assign timer_exp = (timer_reg == 64'h0);

	// Charge state machine
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			state_reg <= CCC_STANDBY;
		end else if (!in_ok) begin
			state_reg <= CCC_STANDBY;
		end else if (heavy) begin
			state_reg <= CCC_OVERRIDE;
		end else if (cmd_halt) begin
			state_reg <= CCC_STANDBY;
		end else if (cmd_begin) begin
			state_reg <= CCC_PRECHARGE;
		end else begin
			unique case (state_reg)
				CCC_PRECHARGE: begin
					if (full_ok) begin
						state_reg <= CCC_FULL_RATE;
					end else if (timer_exp) begin
						state_reg <= CCC_STANDBY;
					end
				end
				CCC_FULL_RATE: begin
					if (timer_exp) begin
						state_reg <= CCC_STANDBY;
					end else if (sync2_reg.at_term) begin
						state_reg <= CCC_CONST_VOLT;
					end
				end
				CCC_CONST_VOLT: begin
					if (timer_exp) begin
						state_reg <= CCC_STANDBY;
					end else if (eoc_hit && auto_en) begin
						state_reg <= CCC_STANDBY;
					end
				end
				CCC_STANDBY: begin
					if (restart_hit && auto_en) begin
						state_reg <= CCC_PRECHARGE;
					end
				end
				CCC_OVERRIDE: begin
					state_reg <= CCC_PRECHARGE;
				end
			endcase
		end
	end

	// Completed-cycle marker arms restart detection
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			cycle_done_reg <= 1'b0;
		end else if (heavy || !in_ok || cmd_begin) begin
			cycle_done_reg <= 1'b0;
		end else if (eoc_hit && auto_en) begin
			cycle_done_reg <= 1'b1;
		end else if (restart_hit && auto_en) begin
			cycle_done_reg <= 1'b0;
		end
	end

	// Safety timer, loaded with the precharge count in standby or override and with the full count on entry to full rate
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			timer_reg <= 64'h0;
		end else if (state_reg == CCC_STANDBY || state_reg == CCC_OVERRIDE) begin
			timer_reg <= PRE_CYC;
		end else if (state_reg == CCC_PRECHARGE && full_ok) begin
			timer_reg <= FULL_CYC;
		end else if (!timer_exp) begin
			timer_reg <= timer_reg - 64'h1;
		end
	end

	// Delayed input-ok to see the start of charger operation
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			in_ok_q_reg <= 1'b0;
		end else begin
			in_ok_q_reg <= in_ok;
		end
	end

	// Routing switch control; opens once when a valid input is accepted
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			switch_reg <= 1'b1;
		end else if (!in_ok) begin
			switch_reg <= 1'b1;
		end else if (heavy) begin
			switch_reg <= 1'b1;
		end else if (!in_ok_q_reg) begin
			switch_reg <= 1'b0;
		end else if (sync2_reg.pmu_standby) begin
			switch_reg <= 1'b0;
		end else if (cmd_close) begin
			switch_reg <= 1'b1;
		end else if (cmd_open) begin
			switch_reg <= 1'b0;
		end else if (overload_close) begin
			switch_reg <= 1'b1;
		end
	end

	// Sticky events: 0 end, 1 begin, 2 auto-close; set wins over clear
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			event_reg <= 4'h0;
		end else begin
			event_reg <= ((wr_event ? event_reg & ~hwdata[3:0] : event_reg) |
				{1'b0, overload_close & ~sync2_reg.pmu_standby & ~cmd_open,
				restart_hit & ~heavy, eoc_hit & ~heavy});
		end
	end

	// Power stage drive
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			drive_out <= '0;
		end else begin
			drive_out.switch_on <= switch_reg;
			drive_out.battery_branch_en <= in_ok & (heavy | (~switch_reg &
				(state_reg != CCC_STANDBY)));
			drive_out.system_branch_en <= in_ok;
			drive_out.input_limit_en <= in_ok & ~heavy;
			drive_out.limit_from_battery_current_code <= in_ok & switch_reg & ~heavy;
			drive_out.current_code <= ctrl_reg[`CCC_CTRL_BATTERY_CURRENT_CODE_MSB:`CCC_CTRL_BATTERY_CURRENT_CODE_LSB];
		end
	end
endmodule

// ===== hdl/ccc_cfg.svh
// Purpose: Constants for the charge cycle controller (offsets, fields, resets, timing)
// Assumes: ref_clk at 50 MHz; AHB-Lite word registers
// Notes: Timing counts derived from printed times and the clock rate
//
// Summary of operation
// - Auto-control bit 0 means manual-only cycles; 1 enables automatic start and stop.
// - Begin and halt commands are write-only and act immediately in manual or automatic mode; heavy-load mode ignores them.
// - End-of-charge after termination voltage, current below threshold for qualify time.
// - Restart armed after completed cycle in standby; voltage low for restart time.
// - Manual mode still raises charge-end events on auto conditions; charge-begin needs a cycle completed in auto mode.
// - From the first clock after reset, routing switch is ON whenever no valid charger input is present.
// - Switch OFF while charging; closes on overload and raises auto-close event.
// - Once closed while charging, switch only reopens on PMU standby or an open-path command.
// - Outside heavy-load mode, with switch ON only system branch works, limited by battery current code.
// - While charging, close-path command turns switch ON, open-path turns it OFF.
// - Heavy-load mode forces switch ON, no input limit, both branches, ignores controls.
// - Input-in-range deglitch: rising 50 ms, falling 2 us.
// - Full-rate and restart comparators are deglitched 400 ms both ways; end-of-charge current 400 ms on rising only, 1 clock on falling.
// - That deglitch is selectable between 400 ms and 210 ms.
// - Safety timers default to 45 minutes precharge and 5 hours full charge.
// - Precharge moves to full rate at full-rate level, else isolates on timeout.
// - Full-charge timeout ends charging into standby with battery isolated.
`ifndef CCC_CFG_SVH
`define CCC_CFG_SVH

// Register byte offsets
`define CCC_CTRL_OFS 12'h000
`define CCC_CMD_OFS 12'h004
`define CCC_STATUS_OFS 12'h008
`define CCC_EVENT_OFS 12'h00c

// Control register fields
`define CCC_CTRL_AUTO_BIT 0
`define CCC_CTRL_HEAVY_BIT 1
`define CCC_CTRL_LONG_DG_BIT 2
`define CCC_CTRL_RESTART_EN_BIT 3
`define CCC_CTRL_EOC_ABS_BIT 4
`define CCC_CTRL_EOC_LVL_LSB 8
`define CCC_CTRL_EOC_LVL_MSB 11
`define CCC_CTRL_BATTERY_CURRENT_CODE_LSB 12
`define CCC_CTRL_BATTERY_CURRENT_CODE_MSB 15
`define CCC_CTRL_RESET 32'h0000_000d

// Command register fields
`define CCC_CMD_BEGIN_BIT 0
`define CCC_CMD_HALT_BIT 1
`define CCC_CMD_CLOSE_BIT 2
`define CCC_CMD_OPEN_BIT 3

// Timing (clock rate, times as printed, cycle counts)
`define CCC_CLK_HZ 50000000
`define CCC_IN_RISE_MS 50
`define CCC_IN_FALL_US 2
`define CCC_DG_LONG_MS 400
`define CCC_DG_SHORT_MS 210
`define CCC_PRE_MIN 45
`define CCC_FULL_HRS 5
`define CCC_IN_RISE_CYC (`CCC_IN_RISE_MS * (`CCC_CLK_HZ / 1000))
`define CCC_IN_FALL_CYC (`CCC_IN_FALL_US * (`CCC_CLK_HZ / 1000000))
`define CCC_DG_LONG_CYC (`CCC_DG_LONG_MS * (`CCC_CLK_HZ / 1000))
`define CCC_DG_SHORT_CYC (`CCC_DG_SHORT_MS * (`CCC_CLK_HZ / 1000))
`define CCC_PRE_CYC (64'd60 * `CCC_PRE_MIN * `CCC_CLK_HZ)
`define CCC_FULL_CYC (64'd3600 * `CCC_FULL_HRS * `CCC_CLK_HZ)

`endif

// ===== hdl/ccc_pkg.sv
// Purpose: Types for the charge cycle controller
// Assumes: Constants live in ccc_cfg.svh
// Notes: None
package ccc_pkg;
	typedef enum logic [2:0] {
		CCC_PRECHARGE,
		CCC_FULL_RATE,
		CCC_CONST_VOLT,
		CCC_STANDBY,
		CCC_OVERRIDE
	} ccc_state_t;

	// Analog comparator results
	typedef struct packed {
		logic in_range;
		logic above_full_rate;
		logic at_term;
		logic below_restart;
		logic cur_below_abs;
		logic cur_below_rel;
		logic overload;
		logic pmu_standby;
	} ccc_comp_t;

	// Branch and switch controls
	typedef struct packed {
		logic switch_on;
		logic battery_branch_en;
		logic system_branch_en;
		logic input_limit_en;
		logic limit_from_battery_current_code;
		logic [3:0] current_code;
	} ccc_drive_t;
endpackage

// ===== hdl/ccc_deglitch.sv
// Purpose: Asymmetric persistence filter for one comparator level
// Assumes: Input already synchronised to ref_clk
// Notes: Counts clear when the input matches the accepted level; a change must hold for the whole count
`timescale 1ns/100ps
module ccc_deglitch (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// Level and hold times
	input wire logic level_in,
	input wire logic [31:0] rise_cyc,
	input wire logic [31:0] fall_cyc,
	// Filtered level
	output logic level_out
);
	logic [31:0] cnt_reg;

	// Count while the input differs from the accepted level
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_reg <= 32'h0000_0000;
			level_out <= 1'b0;
		end else if (level_in == level_out) begin
			cnt_reg <= 32'h0000_0000;
		end else if (cnt_reg + 32'h0000_0001 >= (level_in ? rise_cyc : fall_cyc)) begin
			cnt_reg <= 32'h0000_0000;
			level_out <= level_in;
		end else begin
			cnt_reg <= cnt_reg + 32'h0000_0001;
		end
	end
endmodule

// ===== testbench/ccc_core_sva.sv
// Purpose: Port assertions for the charge cycle controller
// Assumes: Short count parameters in simulation
// Notes: Bound into ccc_core
`timescale 1ns/100ps
`include "ccc_cfg.svh"
module ccc_chk import ccc_pkg::*; #(
	parameter logic [31:0] IN_RISE_CYC = 32'h14
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// Bus
	input wire logic hsel,
	input wire logic [11:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	// Comparators and drives
	input wire ccc_comp_t comp_in,
	input wire ccc_drive_t drive_out
);
	localparam int LIM = int'(IN_RISE_CYC) + 8;
	logic ap_q;
	logic [11:0] a_q;
	logic [31:0] up;
	logic [31:0] dn;
	logic [31:0] since;
	default clocking dc @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	// Marks the data phase of a word write
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			ap_q <= 1'b0;
			a_q <= 12'h0;
		end else begin
			ap_q <= hsel & htrans[1] & hready & hwrite & (hsize == 3'h2);
			a_q <= haddr;
		end
	end
	wire cmd_wr = ap_q && a_q == `CCC_CMD_OFS;
	wire ctl_wr = ap_q && a_q == `CCC_CTRL_OFS;
	// Input run lengths and cycles since a lawful switch release cause
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			up <= 32'h0;
			dn <= 32'h0;
			since <= 32'h0;
		end else begin
			up <= comp_in.in_range ? up + 32'h1 : 32'h0;
			dn <= comp_in.in_range ? 32'h0 : dn + 32'h1;
			since <= (!comp_in.in_range || comp_in.pmu_standby || ctl_wr ||
				(cmd_wr && hwdata[3])) ? 32'h0 : since + 32'h1;
		end
	end
	property p_ready;
		hreadyout;
	endproperty
	a_ready: assert property (p_ready) else $error("wait state seen");
	property p_okay;
		!hresp;
	endproperty
	a_okay: assert property (p_okay) else $error("error response seen");
	property p_no_input;
		dn > 32'h6e |-> drive_out.switch_on;
	endproperty
	a_no_input: assert property (p_no_input) else $error("switch off without input");
	property p_auto_close;
		comp_in.overload [*3] ##0 up > LIM |-> ##[0:6] drive_out.switch_on;
	endproperty
	a_auto_close: assert property (p_auto_close) else $error("no close on overload");
	property p_stays_on;
		$fell(drive_out.switch_on) |-> since < LIM;
	endproperty
	a_stays_on: assert property (p_stays_on) else $error("switch opened by itself");
	property p_branch;
		drive_out.switch_on && drive_out.input_limit_en && drive_out.system_branch_en
			|-> drive_out.limit_from_battery_current_code && !drive_out.battery_branch_en;
	endproperty
	a_branch: assert property (p_branch) else $error("wrong branch with switch on");
	property p_close;
		cmd_wr && hwdata[2] && !hwdata[3] && up > LIM |-> ##[1:4] drive_out.switch_on;
	endproperty
	a_close: assert property (p_close) else $error("close command ignored");
	property p_heavy;
		ctl_wr && hwdata[1] && up > LIM |-> ##[1:4] (drive_out.switch_on &&
			!drive_out.input_limit_en && drive_out.battery_branch_en &&
			drive_out.system_branch_en);
	endproperty
	a_heavy: assert property (p_heavy) else $error("heavy mode drive wrong");
	c_close: cover property (cmd_wr && hwdata[2]);
	c_fall: cover property ($fell(drive_out.switch_on));
	c_heavy: cover property (ctl_wr && hwdata[1]);
endmodule
bind ccc_core ccc_chk #(.IN_RISE_CYC(IN_RISE_CYC)) i_chk (.ref_clk(ref_clk), .rst_b(rst_b),
	.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
	.hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
	.comp_in(comp_in), .drive_out(drive_out));

// ===== testbench/ccc_core_tb_top.sv
// Purpose: Self-checking bench for the charge cycle controller
// Assumes: Short timer parameters; zero-wait bus slave
// Notes: Comparator levels driven directly
`timescale 1ns/100ps
`include "ccc_cfg.svh"
module ccc_core_tb_top import ccc_pkg::*;;
	localparam int PRE = 200;
	localparam int FULL = 400;
	localparam int RISE = 20;
	localparam int DGL = 10;
	localparam logic [11:0] CT = `CCC_CTRL_OFS;
	localparam logic [11:0] CM = `CCC_CMD_OFS;
	localparam logic [11:0] ST = `CCC_STATUS_OFS;
	localparam logic [11:0] EV = `CCC_EVENT_OFS;
	logic ref_clk = 1'b0;
	logic rst_b = 1'b0;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [11:0] haddr = 12'h0;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic [31:0] v;
	logic hreadyout;
	logic hresp;
	ccc_comp_t comp = '0;
	ccc_drive_t drv;
	int fail_count = 0;
	int checked = 0;
	wire [31:0] sw = {31'h0, drv.switch_on};
	wire [31:0] bat = {31'h0, drv.battery_branch_en};
	ccc_core #(.PRE_CYC(64'(PRE)), .FULL_CYC(64'(FULL)), .IN_RISE_CYC(32'(RISE)),
		.DG_LONG_CYC(32'(DGL)), .DG_SHORT_CYC(32'h5)) i_dut (.ref_clk(ref_clk),
		.rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .comp_in(comp), .drive_out(drv));
	// Clock
	initial forever #10 ref_clk = ~ref_clk;
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
	endtask
	// One word transfer; entered just after a rising edge
	task automatic ahb(input logic [11:0] a, input logic w, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= w;
		hsize <= 3'h2;
		do @(posedge ref_clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge ref_clk); while (hreadyout !== 1'b1);
		v = hrdata;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic rdc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
		ahb(a, 1'b0, 32'h0);
		chk(v & m, e);
	endtask
	task automatic results;
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// Watchdog
	initial begin
		cyc(5000);
		fail_count++;
		results;
	end
	// Test sequence
	initial begin
		cyc(2);
		rst_b <= 1'b1;
		rdc(CT, 32'hffff, `CCC_CTRL_RESET);
		rdc(ST, 32'hff, 32'h23);
		rdc(CM, 32'hffffffff, 32'h0);
		rdc(12'h010, 32'hffffffff, 32'h0);
		chk(sw, 32'h1);
		comp.in_range <= 1'b1;
		cyc(RISE - 6);
		rdc(ST, 32'h40, 32'h0);
		cyc(12);
		rdc(ST, 32'h60, 32'h40);
		$display("reset and input test done");
		ahb(CT, 1'b1, 32'hc);
		ahb(CM, 1'b1, 32'h1);
		rdc(ST, 32'h7, 32'h0);
		comp.above_full_rate <= 1'b1;
		cyc(DGL - 4);
		rdc(ST, 32'h7, 32'h0);
		cyc(10);
		rdc(ST, 32'h7, 32'h1);
		comp.at_term <= 1'b1;
		comp.cur_below_rel <= 1'b1;
		cyc(2 * DGL + 16);
		rdc(ST, 32'h7, 32'h2);
		rdc(EV, 32'h1, 32'h1);
		ahb(CM, 1'b1, 32'h2);
		rdc(ST, 32'h7, 32'h3);
		$display("manual cycle test done");
		comp.above_full_rate <= 1'b0;
		cyc(DGL + 8);
		ahb(CM, 1'b1, 32'h1);
		cyc(2);
		chk(bat, 32'h1);
		cyc(PRE + 10);
		chk(bat, 32'h0);
		comp.at_term <= 1'b0;
		comp.above_full_rate <= 1'b1;
		cyc(DGL + 8);
		ahb(CM, 1'b1, 32'h2);
		ahb(CM, 1'b1, 32'h1);
		cyc(FULL + 20);
		rdc(ST, 32'h7, 32'h3);
		chk(bat, 32'h0);
		$display("safety timer test done");
		ahb(CT, 1'b1, 32'ha00d);
		comp.at_term <= 1'b1;
		ahb(CM, 1'b1, 32'h1);
		cyc(2 * DGL + 20);
		rdc(ST, 32'h87, 32'h83);
		comp.below_restart <= 1'b1;
		cyc(DGL + 8);
		rdc(EV, 32'h2, 32'h2);
		comp.below_restart <= 1'b0;
		$display("automatic cycle test done");
		ahb(CM, 1'b1, 32'h4);
		cyc(4);
		chk(sw, 32'h1);
		chk({25'h0, bat[0], drv.system_branch_en, drv.limit_from_battery_current_code, drv.current_code},
			32'h3a);
		ahb(CM, 1'b1, 32'h8);
		cyc(4);
		chk(sw, 32'h0);
		comp.overload <= 1'b1;
		cyc(8);
		chk(sw, 32'h1);
		comp.overload <= 1'b0;
		cyc(20);
		chk(sw, 32'h1);
		rdc(EV, 32'h4, 32'h4);
		comp.pmu_standby <= 1'b1;
		cyc(6);
		chk(sw, 32'h0);
		comp.pmu_standby <= 1'b0;
		$display("switch test done");
		ahb(CT, 1'b1, 32'ha00f);
		cyc(3);
		rdc(ST, 32'h7, 32'h4);
		chk({28'h0, sw[0], bat[0], drv.system_branch_en, drv.input_limit_en}, 32'he);
		ahb(CM, 1'b1, 32'h2);
		rdc(ST, 32'h7, 32'h4);
		ahb(CT, 1'b1, 32'ha00d);
		comp.in_range <= 1'b0;
		cyc(80);
		rdc(ST, 32'h40, 32'h40);
		cyc(30);
		rdc(ST, 32'h40, 32'h0);
		chk(sw, 32'h1);
		$display("heavy mode and input loss test done");
		results;
	end
endmodule
